// ==== rtl/uv_oc_fault_response_ctrl.sv ====
// Purpose: command registers and fault response for output under-voltage
//   and high-side peak over-current
// Assumes: command port driven by the bus engine on clk; uv_detect_in is
//   an analog comparator output and is synchronised here
// Notes: the peak current sample is a same-clock code in 2 A units
// Function
// (R1) uv fault sets vout summary, uv bit, alert
// (R2) fault bits sticky until clear-faults
// (R3) uv threshold from percent-limit bits 5:3
// (R4) reset values 0x40 and 0x80
// (R5) uv mode 00 continue, 01 delay; others invalid
// (R6) retry 000 latch-off, 111 hiccup 1 s
// (R7) uv delay uses bits 1:0, bit 2 ignored
// (R8) unsupported response values flag invalid data
// (R9) limit linear format, exponent fixed at 1
// (R10) limit codes 0801..081F, reset 081B
// (R11) compare limit with high-side peak current
// (R12) oc fault sets iout bits and alert
// (R13) oc mode 00 keeps running at limit
// (R14) oc mode 01 runs until under-voltage; here the oc fault only sets flags, no current limit
// (R15) oc mode 10 limits for delay, then retry
// (R16) oc mode 11 shuts down, then retry
// (R17) oc delay windows in 160 us steps
// (R18) store-all copies three registers to nvm
// (R19) rejected write keeps old value
// (R20) delays timed by 160 us core tick; uv delays count clk cycles instead
`timescale 1ns/10ps
module uv_oc_fault_response_ctrl
#(
    parameter int unsigned OC_TICK_CYCLES = fault_resp_pkg::OC_TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire fault_resp_pkg::host_cmd_t cmd,
    input wire logic clear_faults,
    input wire logic store_user_all,
    input wire logic output_on_cmd,
    input wire logic uv_detect_in,
    input wire logic [10:0] hs_peak_current,
    input wire logic [15:0] output_threshold_percent_cfg,
    output logic [15:0] rsp_data_q,
    output logic rsp_valid_q,
    output fault_resp_pkg::fault_status_t status_q,
    output logic host_alert_out_n,
    output logic [2:0] uv_threshold_sel_q,
    output logic [10:0] peak_limit_mant_q,
    output logic regulator_en_q,
    output logic current_limit_q,
    output logic nvm_wr_q,
    output fault_resp_pkg::nvm_image_t nvm_image_q
);
    import fault_resp_pkg::*;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_UV_DELAY,
        ST_OC_DELAY,
        ST_LATCHED,
        ST_HICCUP,
        ST_OFF
    } resp_state_t;

    function automatic logic retry_ok(input logic [7:0] v);
        logic [2:0] r;
        r = v[RETRY_MSB:RETRY_LSB];
        retry_ok = (r == RETRY_LATCH) || (r == RETRY_HICCUP);
    endfunction

    function automatic logic is_hiccup(input logic [7:0] v);
        is_hiccup = (v[RETRY_MSB:RETRY_LSB] == RETRY_HICCUP);
    endfunction

    function automatic logic [12:0] uv_delay_cycles(input logic [1:0] sel);
        unique case (sel)
            2'h0: uv_delay_cycles = 13'(UV_DLY0_CYC);
            2'h1: uv_delay_cycles = 13'(UV_DLY1_CYC);
            2'h2: uv_delay_cycles = 13'(UV_DLY2_CYC);
            2'h3: uv_delay_cycles = 13'(UV_DLY3_CYC);
        endcase
    endfunction

    // edges of the free tick to wait; start phase is random, hence window
    function automatic logic [12:0] oc_delay_ticks(input logic [2:0] sel);
        unique case (sel)
            3'h0: oc_delay_ticks = 13'(OC_DLY0_TK + 1);
            3'h1: oc_delay_ticks = 13'(OC_DLY1_TK + 1);
            3'h2: oc_delay_ticks = 13'(OC_DLY2_TK + 1);
            3'h3: oc_delay_ticks = 13'(OC_DLY3_TK + 1);
            3'h4: oc_delay_ticks = 13'(OC_DLY4_TK + 1);
            3'h5: oc_delay_ticks = 13'(OC_DLY5_TK + 1);
            3'h6: oc_delay_ticks = 13'(OC_DLY6_TK + 1);
            3'h7: oc_delay_ticks = 13'(OC_DLY7_TK + 1);
        endcase
    endfunction

    logic [7:0] uv_action_q;
    logic [15:0] peak_limit_q;
    logic [7:0] oc_action_q;
    logic uv_meta_q;
    logic uv_sync_q;
    logic oc_hit_q;
    logic tick;
    logic wr_uv;
    logic wr_limit;
    logic wr_oc;
    logic bad_write;
    resp_state_t state_q;
    resp_state_t state_d;
    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    action_mode_t uv_mode;
    action_mode_t oc_mode;

    assign uv_mode = action_mode_t'(uv_action_q[MODE_MSB:MODE_LSB]);
    assign oc_mode = action_mode_t'(oc_action_q[MODE_MSB:MODE_LSB]);

    // oc delay and hiccup timebase [R20]
    tick_divider #(
        .DIV(OC_TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick_q(tick)
    );

    // comparator output is asynchronous to clk
    always_ff @(posedge clk) begin
        if (rst) begin
            uv_meta_q <= 1'b0;
            uv_sync_q <= 1'b0;
        end else begin
            uv_meta_q <= uv_detect_in;
            uv_sync_q <= uv_meta_q;
        end
    end

    // peak current crossing the programmed limit [R11]
    always_ff @(posedge clk) begin
        if (rst) begin
            oc_hit_q <= 1'b0;
        end else begin
            oc_hit_q <= hs_peak_current >= peak_limit_q[MANT_MSB:0];
        end
    end

    // write checks; bits 2:0 of the uv byte carry no check [R7]
    always_comb begin
        wr_uv = 1'b0;
        wr_limit = 1'b0;
        wr_oc = 1'b0;
        bad_write = 1'b0;
        if (cmd.valid && cmd.write) begin
            unique case (cmd.code)
                UV_ACTION_OFS: begin
                    // modes 10 and 11 unsupported for uv [R5] [R8]
                    if (!cmd.data[MODE_MSB] && retry_ok(cmd.data[7:0])) begin
                        wr_uv = 1'b1;
                    end else begin
                        bad_write = 1'b1; // [R6] [R8]
                    end
                end
                PEAK_LIMIT_OFS: begin
                    if (cmd.data[EXP_MSB:EXP_LSB] == LIMIT_EXP &&
                        cmd.data[MANT_MSB:0] >= LIMIT_MANT_MIN &&
                        cmd.data[MANT_MSB:0] <= LIMIT_MANT_MAX) begin
                        wr_limit = 1'b1;
                    end else begin
                        bad_write = 1'b1; // [R9] [R10]
                    end
                end
                OC_ACTION_OFS: begin
                    if (retry_ok(cmd.data[7:0])) begin
                        wr_oc = 1'b1;
                    end else begin
                        bad_write = 1'b1; // [R6] [R8]
                    end
                end
                default: ;
            endcase
        end
    end

    // invalid writes never reach the registers [R19]
    always_ff @(posedge clk) begin
        if (rst) begin
            uv_action_q <= UV_ACTION_RST; // [R4]
        end else if (wr_uv) begin
            uv_action_q <= cmd.data[7:0];
        end
    end

    // exponent bits are only ever loaded with the fixed value [R9]
    always_ff @(posedge clk) begin
        if (rst) begin
            peak_limit_q <= PEAK_LIMIT_RST; // [R10]
        end else if (wr_limit) begin
            peak_limit_q <= {LIMIT_EXP, cmd.data[MANT_MSB:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            oc_action_q <= OC_ACTION_RST; // [R4]
        end else if (wr_oc) begin
            oc_action_q <= cmd.data[7:0];
        end
    end

    // read answers one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
        end else begin
            rsp_valid_q <= cmd.valid && !cmd.write;
            unique case (cmd.code)
                UV_ACTION_OFS: rsp_data_q <= {8'h00, uv_action_q};
                PEAK_LIMIT_OFS: rsp_data_q <= peak_limit_q;
                OC_ACTION_OFS: rsp_data_q <= {8'h00, oc_action_q};
                default: rsp_data_q <= 16'h0000;
            endcase
        end
    end

    // sticky flags; a live fault or event wins over clear-faults [R2]
    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= '0;
        end else begin
            status_q.vout_uv_fault <= uv_sync_q ||
                (status_q.vout_uv_fault && !clear_faults); // [R1]
            status_q.word_vout <= uv_sync_q ||
                (status_q.word_vout && !clear_faults); // [R1]
            status_q.iout_oc_peak <= oc_hit_q ||
                (status_q.iout_oc_peak && !clear_faults); // [R12]
            status_q.word_iout <= oc_hit_q ||
                (status_q.word_iout && !clear_faults); // [R12]
            status_q.byte_iout <= oc_hit_q ||
                (status_q.byte_iout && !clear_faults); // [R12]
            status_q.cml_invalid_data <= bad_write ||
                (status_q.cml_invalid_data && !clear_faults); // [R8]
        end
    end

    // alert follows any flag, one cycle behind it [R1] [R12]
    always_ff @(posedge clk) begin
        if (rst) begin
            host_alert_out_n <= 1'b1;
        end else begin
            host_alert_out_n <= !(|status_q);
        end
    end

    // threshold select goes to the uv comparator [R3]
    always_ff @(posedge clk) begin
        if (rst) begin
            uv_threshold_sel_q <= 3'h0;
            peak_limit_mant_q <= PEAK_LIMIT_RST[MANT_MSB:0];
        end else begin
            uv_threshold_sel_q <=
                output_threshold_percent_cfg[PCT_UV_MSB:PCT_UV_LSB];
            peak_limit_mant_q <= peak_limit_q[MANT_MSB:0];
        end
    end

    // response sequencer; in ST_RUN oc shutdown outranks uv handling; ST_UV_DELAY ignores oc
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            ST_RUN: begin
                if (oc_hit_q && oc_mode == MODE_SHUTDOWN) begin
                    state_d = is_hiccup(oc_action_q) ? ST_HICCUP : ST_LATCHED;
                    cnt_d = '0; // [R16]
                end else if (oc_hit_q && oc_mode == MODE_LIMIT_DELAY) begin
                    state_d = ST_OC_DELAY; // [R15]
                    cnt_d = '0;
                end else if (uv_sync_q && uv_mode == MODE_DELAY) begin
                    state_d = ST_UV_DELAY; // [R5] [R14]
                    cnt_d = '0;
                end
            end
            ST_UV_DELAY: begin
                if (!uv_sync_q) begin
                    state_d = ST_RUN;
                end else if (cnt_q + 13'h1 >=
                             uv_delay_cycles(uv_action_q[1:0])) begin
                    // still low after the delay: take the retry path [R5]
                    state_d = is_hiccup(uv_action_q) ? ST_HICCUP : ST_LATCHED;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 13'h1; // [R7]
                end
            end
            ST_OC_DELAY: begin
                if (!oc_hit_q) begin
                    state_d = ST_RUN;
                end else if (tick && cnt_q + 13'h1 >=
                             oc_delay_ticks(oc_action_q[2:0])) begin
                    state_d = is_hiccup(oc_action_q) ? ST_HICCUP : ST_LATCHED;
                    cnt_d = '0; // [R15]
                end else if (tick) begin
                    cnt_d = cnt_q + 13'h1; // [R17]
                end
            end
            ST_LATCHED: begin
                if (clear_faults) begin
                    state_d = ST_RUN; // [R6]
                end
            end
            ST_HICCUP: begin
                if (tick && cnt_q + 13'h1 >= 13'(HICCUP_TICKS)) begin
                    state_d = ST_RUN; // [R6]
                    cnt_d = '0;
                end else if (tick) begin
                    cnt_d = cnt_q + 13'h1;
                end
            end
            ST_OFF: begin
                if (output_on_cmd) begin
                    state_d = ST_RUN;
                    cnt_d = '0;
                end
            end
        endcase
        // commanded off ends any hiccup or delay [R6]
        if (!output_on_cmd) begin
            state_d = ST_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_RUN;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // output enable follows the next state, so it is exact to the cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            regulator_en_q <= 1'b0;
            current_limit_q <= 1'b0;
        end else begin
            regulator_en_q <= state_d == ST_RUN ||
                state_d == ST_UV_DELAY || state_d == ST_OC_DELAY;
            // modes 00 and 10 clamp current at the limit [R13] [R15]
            current_limit_q <= oc_hit_q && !oc_mode[0] &&
                (state_d == ST_RUN || state_d == ST_OC_DELAY ||
                 state_d == ST_UV_DELAY);
        end
    end

    // snapshot of all three registers for the nvm writer [R18]
    always_ff @(posedge clk) begin
        if (rst) begin
            nvm_wr_q <= 1'b0;
            nvm_image_q <= {UV_ACTION_RST, PEAK_LIMIT_RST, OC_ACTION_RST};
        end else begin
            nvm_wr_q <= store_user_all;
            if (store_user_all) begin
                nvm_image_q <= {uv_action_q, peak_limit_q, oc_action_q};
            end
        end
    end
endmodule

// ==== pkg/fault_resp_pkg.sv ====
// Purpose: shared constants and carriers for the fault response block
// Assumes: 50 MHz core clock, command codes as used on the host bus
// Notes: times are kept in their own unit, cycle counts derive from them
package fault_resp_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;

    localparam logic [7:0] UV_ACTION_OFS = 8'h45;
    localparam logic [7:0] PEAK_LIMIT_OFS = 8'h46;
    localparam logic [7:0] OC_ACTION_OFS = 8'h47;

    localparam logic [7:0] UV_ACTION_RST = 8'h40;
    localparam logic [15:0] PEAK_LIMIT_RST = 16'h081B;
    localparam logic [7:0] OC_ACTION_RST = 8'h80;

    localparam int unsigned MODE_MSB = 7;
    localparam int unsigned MODE_LSB = 6;
    localparam int unsigned RETRY_MSB = 5;
    localparam int unsigned RETRY_LSB = 3;
    localparam int unsigned EXP_MSB = 15;
    localparam int unsigned EXP_LSB = 11;
    localparam int unsigned MANT_MSB = 10;
    localparam int unsigned PCT_UV_MSB = 5;
    localparam int unsigned PCT_UV_LSB = 3;

    localparam logic [2:0] RETRY_LATCH = 3'h0;
    localparam logic [2:0] RETRY_HICCUP = 3'h7;
    localparam logic [4:0] LIMIT_EXP = 5'h01;
    localparam logic [10:0] LIMIT_MANT_MIN = 11'h001;
    localparam logic [10:0] LIMIT_MANT_MAX = 11'h01F;

    // under-voltage delays, ns; least times round up
    localparam int unsigned UV_DLY0_NS = 6250;
    localparam int unsigned UV_DLY1_NS = 7500;
    localparam int unsigned UV_DLY2_NS = 8750;
    localparam int unsigned UV_DLY3_NS = 10000;
    localparam int unsigned UV_DLY0_CYC =
        (UV_DLY0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UV_DLY1_CYC =
        (UV_DLY1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UV_DLY2_CYC =
        (UV_DLY2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UV_DLY3_CYC =
        (UV_DLY3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // over-current delay tick and hiccup time
    localparam int unsigned OC_TICK_US = 160;
    localparam int unsigned OC_TICK_CYC = OC_TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned HICCUP_US = 1000000;
    localparam int unsigned HICCUP_TICKS = HICCUP_US / OC_TICK_US;

    // over-current delay window lower bounds, in ticks (window = +1 tick)
    localparam int unsigned OC_DLY0_TK = 1;
    localparam int unsigned OC_DLY1_TK = 2;
    localparam int unsigned OC_DLY2_TK = 4;
    localparam int unsigned OC_DLY3_TK = 8;
    localparam int unsigned OC_DLY4_TK = 16;
    localparam int unsigned OC_DLY5_TK = 32;
    localparam int unsigned OC_DLY6_TK = 60;
    localparam int unsigned OC_DLY7_TK = 63;

    typedef enum logic [1:0] {
        MODE_CONTINUE = 2'h0,
        MODE_DELAY = 2'h1,
        MODE_LIMIT_DELAY = 2'h2,
        MODE_SHUTDOWN = 2'h3
    } action_mode_t;

    typedef struct packed {
        logic word_vout;
        logic word_iout;
        logic byte_iout;
        logic vout_uv_fault;
        logic iout_oc_peak;
        logic cml_invalid_data;
    } fault_status_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } host_cmd_t;

    typedef struct packed {
        logic [7:0] uv_action;
        logic [15:0] peak_limit;
        logic [7:0] oc_action;
    } nvm_image_t;

endpackage

// ==== rtl/tick_divider.sv ====
// Purpose: free-running divider giving a one-cycle enable pulse
// Assumes: single core clock, synchronous reset
// Notes: first pulse comes DIV cycles after reset release
`timescale 1ns/10ps
module tick_divider #(
    parameter int unsigned DIV = 8000
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick_q
);
    localparam int unsigned CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (rst || cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (cnt_q == LAST);
        end
    end
endmodule

// ==== sim/fault_resp_assertions.sv ====
// Purpose: port-level checks of the fault response block
// Assumes: one clock, rst synchronous active high
// Notes: fault waits carry a cycle of slack over the hand-over timing
`timescale 1ns/10ps
module fault_resp_assertions (
    input logic clk,
    rst,
    clear_faults,
    store_user_all,
    output_on_cmd,
    uv_detect_in,
    rsp_valid_q,
    host_alert_out_n,
    regulator_en_q,
    nvm_wr_q,
    input logic [2:0] uv_threshold_sel_q,
    input logic [10:0] hs_peak_current,
    peak_limit_mant_q,
    input logic [15:0] output_threshold_percent_cfg,
    input fault_resp_pkg::host_cmd_t cmd,
    input fault_resp_pkg::fault_status_t status_q
);
    import fault_resp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence uv_held;
        uv_detect_in [*4];
    endsequence
    sequence oc_held;
        (hs_peak_current >= peak_limit_mant_q) [*3];
    endsequence
    sequence limit_wr;
        cmd.valid && cmd.write && cmd.code == PEAK_LIMIT_OFS;
    endsequence
    sequence good_limit;
        limit_wr and cmd.data inside {[16'h0801:16'h081F]};
    endsequence
    sequence bad_limit;
        limit_wr and !(cmd.data inside {[16'h0801:16'h081F]});
    endsequence
    read_answer_a:
        assert property (cmd.valid && !cmd.write |=> rsp_valid_q)
        else $error("read not answered");
    uv_flags_a:
        assert property (uv_held |=> status_q.word_vout &&
            status_q.vout_uv_fault) else $error("uv flags missing");
    oc_flags_a:
        assert property (oc_held |=> status_q.word_iout &&
            status_q.byte_iout && status_q.iout_oc_peak)
        else $error("oc flags missing");
    alert_low_a:
        assert property ((|status_q) |=> !host_alert_out_n)
        else $error("alert not asserted");
    uv_sticky_a:
        assert property (status_q.vout_uv_fault && !clear_faults |=>
            status_q.vout_uv_fault) else $error("uv flag dropped");
    oc_sticky_a:
        assert property (status_q.iout_oc_peak && !clear_faults |=>
            status_q.iout_oc_peak) else $error("oc flag dropped");
    limit_load_a:
        assert property (good_limit |=> ##1
            peak_limit_mant_q == $past(cmd.data[10:0], 2))
        else $error("limit not loaded");
    limit_reject_a:
        assert property (bad_limit |=> status_q.cml_invalid_data)
        else $error("bad limit not flagged");
    limit_keep_a:
        assert property (bad_limit |=> ##1 $stable(peak_limit_mant_q))
        else $error("bad limit changed register");
    store_copy_a:
        assert property (store_user_all |=> nvm_wr_q)
        else $error("store not issued");
    threshold_sel_a:
        assert property ($stable(output_threshold_percent_cfg) [*3] |->
            uv_threshold_sel_q == output_threshold_percent_cfg[5:3])
        else $error("threshold select wrong");
    off_cmd_a:
        assert property (!output_on_cmd |=> !regulator_en_q)
        else $error("output on while commanded off");
endmodule

bind uv_oc_fault_response_ctrl fault_resp_assertions
    chk_inst (.clk, .rst, .cmd, .clear_faults, .store_user_all,
    .output_on_cmd, .uv_detect_in, .hs_peak_current,
    .output_threshold_percent_cfg, .rsp_valid_q, .status_q,
    .host_alert_out_n, .uv_threshold_sel_q, .peak_limit_mant_q,
    .regulator_en_q, .nvm_wr_q);

// ==== sim/host_model.sv ====
// Purpose: bus-engine side model issuing register commands
// Assumes: requests launched on the falling edge, valid for one cycle
// Notes: idle fields show the inverse of the last request, not a hold
`timescale 1ns/10ps
module host_model (
    input wire logic clk,
    input wire logic [15:0] rsp_data_q,
    input wire logic rsp_valid_q,
    output fault_resp_pkg::host_cmd_t cmd
);
    import fault_resp_pkg::*;
    initial cmd = '0;
    task issue(input logic wr, input logic [7:0] code,
                         input logic [15:0] data);
        @(negedge clk);
        cmd = '{valid: 1'b1, write: wr, code: code, data: data};
        @(negedge clk);
        cmd = '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
    endtask
    task read_reg(input logic [7:0] code,
                            output logic [15:0] data, output logic ok);
        issue(1'b0, code, 16'h0000);
        ok = rsp_valid_q;
        data = rsp_data_q;
    endtask
endmodule

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench for the fault response block
// Assumes: partner issues commands, bench drives the analog side
// Notes: short tick keeps delays and the hiccup wait within reach
`timescale 1ns/10ps
module tb_top;
    import fault_resp_pkg::*;
    logic clk, rst, clear_faults, store_user_all, output_on_cmd;
    logic uv_detect_in, rsp_valid_q, host_alert_out_n, regulator_en_q;
    logic current_limit_q, nvm_wr_q;
    logic [2:0] uv_threshold_sel_q;
    logic [10:0] hs_peak_current, peak_limit_mant_q;
    logic [15:0] output_threshold_percent_cfg, rsp_data_q;
    logic [15:0] exp_uv = 16'h0040, exp_lim = 16'h081B, exp_oc = 16'h0080;
    host_cmd_t cmd;
    fault_status_t status_q;
    nvm_image_t nvm_image_q;
    int error_cnt, comparisons;
    // code, data, accepted
    logic [24:0] tab [16] = '{{8'h45,16'h0080,1'b0}, {8'h45,16'h00C0,1'b0},
        {8'h45,16'h0048,1'b0}, {8'h47,16'h0070,1'b0}, {8'h47,16'h0088,1'b0},
        {8'h46,16'h0800,1'b0}, {8'h46,16'h0820,1'b0}, {8'h46,16'h101B,1'b0},
        {8'h45,16'h1243,1'b1}, {8'h45,16'h007B,1'b1}, {8'h47,16'h0000,1'b1},
        {8'h47,16'h0078,1'b1}, {8'h47,16'h00B9,1'b1}, {8'h46,16'h0801,1'b1},
        {8'h46,16'h081F,1'b1}, {8'h47,16'h00C0,1'b1}};

    uv_oc_fault_response_ctrl #(.OC_TICK_CYCLES(4))
    uv_oc_fault_response_ctrl_inst (.clk, .rst, .cmd, .clear_faults,
        .store_user_all, .output_on_cmd, .uv_detect_in, .hs_peak_current,
        .output_threshold_percent_cfg, .rsp_data_q, .rsp_valid_q,
        .status_q, .host_alert_out_n, .uv_threshold_sel_q,
        .peak_limit_mant_q, .regulator_en_q, .current_limit_q, .nvm_wr_q,
        .nvm_image_q);
    host_model host_model_inst (.clk, .rsp_data_q, .rsp_valid_q, .cmd);

    task check(input string name, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task summarize();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task clr();
        @(negedge clk) clear_faults = 1'b1;
        @(negedge clk) clear_faults = 1'b0;
    endtask
    task wr(input logic [7:0] code, input logic [15:0] data, input ok);
        host_model_inst.issue(1'b1, code, data);
        if (ok) begin
            case (code)
                8'h45: exp_uv = {8'h00, data[7:0]};
                8'h46: exp_lim = data;
                default: exp_oc = {8'h00, data[7:0]};
            endcase
        end
    endtask
    task rd(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host_model_inst.read_reg(code, d, ok);
        check("rsp_valid", ok, 1'b1);
        check("rsp_data", d, exp);
    endtask

    task t_reset();
        check("status", status_q, 6'h00);
        check("alert_n", host_alert_out_n, 1'b1);
        check("mant", peak_limit_mant_q, 11'h01B);
        rd(8'h45, 16'h0040);
        rd(8'h46, 16'h081B);
        rd(8'h47, 16'h0080);
        rd(8'h99, 16'h0000);
        $display("test reset done");
    endtask
    task t_writes();
        for (int i = 0; i < 16; i++) begin
            wr(tab[i][24:17], tab[i][16:1], tab[i][0]);
            check("invalid", status_q.cml_invalid_data, !tab[i][0]);
            rd(8'h45, exp_uv);
            rd(8'h46, exp_lim);
            rd(8'h47, exp_oc);
            check("alert_n", host_alert_out_n, tab[i][0]);
            check("mant", peak_limit_mant_q, exp_lim[10:0]);
            clr();
        end
        $display("test writes done");
    endtask
    task t_oc();
        wr(8'h46, 16'h0805, 1'b1);
        hs_peak_current = 11'd4;
        cyc(5);
        check("oc_below", status_q, 6'h00);
        hs_peak_current = 11'd5;
        cyc(4);
        check("oc_status", status_q, 6'h1A);
        check("oc_alert_n", host_alert_out_n, 1'b0);
        check("oc_shut", regulator_en_q, 1'b0);
        hs_peak_current = 11'd0;
        cyc(10);
        check("oc_sticky", status_q, 6'h1A);
        check("oc_latched", regulator_en_q, 1'b0);
        clr();
        cyc(3);
        check("oc_clear", status_q, 6'h00);
        check("oc_restart", regulator_en_q, 1'b1);
        wr(8'h47, 16'h0000, 1'b1);
        hs_peak_current = 11'd5;
        cyc(4);
        check("oc_limit", current_limit_q, 1'b1);
        check("oc_runs", regulator_en_q, 1'b1);
        wr(8'h47, 16'h0080, 1'b1);
        cyc(1);
        check("oc_in_delay", regulator_en_q, 1'b1);
        cyc(20);
        check("oc_delay_end", regulator_en_q, 1'b0);
        hs_peak_current = 11'd0;
        cyc(3);
        clr();
        wr(8'h47, 16'h0040, 1'b1);
        hs_peak_current = 11'd5;
        cyc(20);
        check("oc_ignore", regulator_en_q, 1'b1);
        output_on_cmd = 1'b0;
        cyc(2);
        check("cmd_off", regulator_en_q, 1'b0);
        output_on_cmd = 1'b1;
        wr(8'h47, 16'h00F8, 1'b1);
        cyc(20);
        check("hiccup_off", regulator_en_q, 1'b0);
        hs_peak_current = 11'd0;
        cyc(25100);
        check("hiccup_on", regulator_en_q, 1'b1);
        clr();
        $display("test overcurrent done");
    endtask
    task t_uv();
        wr(8'h45, 16'h0000, 1'b1);
        uv_detect_in = 1'b1;
        cyc(6);
        check("uv_status", status_q, 6'h24);
        check("uv_alert_n", host_alert_out_n, 1'b0);
        check("uv_continue", regulator_en_q, 1'b1);
        uv_detect_in = 1'b0;
        cyc(4);
        clr();
        // bit 2 set: same 6.25 us wait as code 00
        wr(8'h45, 16'h0044, 1'b1);
        uv_detect_in = 1'b1;
        cyc(300);
        check("uv_in_delay", regulator_en_q, 1'b1);
        cyc(30);
        check("uv_latched", regulator_en_q, 1'b0);
        uv_detect_in = 1'b0;
        cyc(4);
        clr();
        cyc(3);
        check("uv_restart", regulator_en_q, 1'b1);
        $display("test undervoltage done");
    endtask
    task t_store();
        output_threshold_percent_cfg = 16'h0E28;
        @(negedge clk) store_user_all = 1'b1;
        @(negedge clk) store_user_all = 1'b0;
        check("nvm_wr", nvm_wr_q, 1'b1);
        check("nvm", nvm_image_q, {exp_uv[7:0], exp_lim, exp_oc[7:0]});
        check("uv_sel", uv_threshold_sel_q, 3'h5);
        $display("test store done");
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        clear_faults = 1'b0;
        store_user_all = 1'b0;
        output_on_cmd = 1'b1;
        uv_detect_in = 1'b0;
        hs_peak_current = 11'd0;
        output_threshold_percent_cfg = 16'h0010;
        cyc(6);
        rst = 1'b0;
        cyc(2);
        t_reset();
        t_writes();
        t_oc();
        t_uv();
        t_store();
        summarize();
    end
    // tests need about 26000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        summarize();
    end
endmodule
